// file: pcm_voice_port.sv
// Purpose: three-channel full-duplex serial voice port with APB registers
// Assumes: CLK_I 100 MHz; link pins arrive asynchronously and are synchronised
// Notes:   bit clock must stay well below a quarter of CLK_I in slave mode
// Overview of operation
// - master drives bit clock and frame sync
// - slave takes bit clock and sync as inputs
// - three channels, each slot chosen independently
// - slot count follows interface rate and frame rate
// - channel uses same slot both directions
// - data output released on unowned slots
// - release after falling edge of last bit
// - transparent wideband passes host words untouched
// - codec mode carries linear 13-bit samples
// - short and long sync, master or slave
// - short sync: one-bit high pulse, rising aligned
// - slave: sync seen at fall; next rise is bit zero, or bit one for long sync
// - long sync: three bits, starts with bit zero
// - 13 sample bits, position and order configurable
// - spare bits ignored in, filled out selectably
// - reset format: left justified, msb first
// - transfer traffic buffered between bus and link
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ns

// simple synchronous fifo in flip-flops
module pvp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         clk_i,      // clock
  input  wire logic         arst_n_i,   // async reset, active low
  input  wire logic         in_valid_i, // write request
  output logic              in_ready_o, // not full
  input  wire logic [W-1:0] in_data_i,  // write data
  output logic              out_valid_o,// not empty
  input  wire logic         out_ready_i,// read acknowledge
  output logic [W-1:0]      out_data_o  // head entry
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]         mem [D];
  logic [AW-1:0]        wr_ptr;
  logic [AW-1:0]        rd_ptr;
  logic [$clog2(D+1)-1:0] count;
  logic                 do_wr;
  logic                 do_rd;

  assign in_ready_o  = (count != D[$clog2(D+1)-1:0]);
  assign out_valid_o = (count != '0);
  assign do_wr       = in_valid_i & in_ready_o;
  assign do_rd       = out_valid_o & out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  // storage needs no reset, only the pointers and the count do
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers wrap at the depth
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // pvp_fifo

module pcm_voice_port (
  input  wire logic        CLK_I,     // 100 MHz system clock
  input  wire logic        ARST_N_I,  // async reset, active low
  input  wire logic        PSEL_I,    // apb select
  input  wire logic        PENABLE_I, // apb access phase
  input  wire logic        PWRITE_I,  // apb write
  input  wire logic [11:0] PADDR_I,   // apb byte address
  input  wire logic [31:0] PWDATA_I,  // apb write data
  output logic [31:0]      PRDATA_O,  // apb read data
  output logic             PREADY_O,  // apb ready
  output logic             PSLVERR_O, // apb error, unmapped address
  input  wire logic        BCLK_I,    // bit clock pin in
  output logic             BCLK_O,    // bit clock pin out
  output logic             BCLK_OE_O, // bit clock drive enable
  input  wire logic        SYNC_I,    // frame sync pin in
  output logic             SYNC_O,    // frame sync pin out
  output logic             SYNC_OE_O, // frame sync drive enable
  input  wire logic        DIN_I,     // serial data in
  output logic             DOUT_O,    // serial data out
  output logic             DOUT_OE_O  // serial data drive enable
);
  import pcm_voice_port_pkg::*;

  ctrl_s       shd_ctrl, act_ctrl;
  fmt_s        shd_fmt, act_fmt;
  chan_s [2:0] shd_chan, act_chan;
  status_s     stat;
  logic        underrun, overrun;
  logic [1:0]  bclk_sy, sync_sy, din_sy;
  logic        bclk_d;
  logic [9:0]  div_cnt;
  logic        bclk_m;
  logic        rise_ev, fall_ev;
  logic [8:0]  bit_cnt, next_bit_cnt, frame_last;
  logic        pend;
  logic [8:0]  pend_val;
  logic        prev_fs;
  logic [4:0]  nslots;
  logic [2:0]  hit_nx, hit_cu;
  logic [1:0]  ch_cu;
  logic        own_nx, own_cu;
  logic [15:0] tx_sh, rx_sh, tx_word, rx_full;
  logic        oe, rel_q;
  logic        sync_q;
  logic        tx_pop, tx_in_rdy, tx_out_val;
  logic [15:0] tx_head;
  logic        rx_push, rx_in_rdy, rx_out_val, rx_pop;
  logic [17:0] rx_data, rx_head;
  logic        acc, wr_tx, wr_hit;

  // bit reversal for lsb-first shifting
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < `PVP_SLOT_BITS; i++) begin
      r[i] = v[`PVP_SLOT_BITS-1-i];
    end
    return r;
  endfunction

  // divider reload: half period of the master bit clock in CLK_I cycles, less one
  function automatic logic [9:0] half_div(input logic [2:0] r);
    return 10'(`PVP_CLK_KHZ / ((`PVP_BASE_RATE_KHZ << r) * 2) - 1);
  endfunction

  // ---------------- pin synchronisers ----------------
  // two flops before anything reads a pin
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bclk_sy <= '0;
      sync_sy <= '0;
      din_sy  <= '0;
      bclk_d  <= 1'b0;
    end else begin
      bclk_sy <= {bclk_sy[0], BCLK_I};
      sync_sy <= {sync_sy[0], SYNC_I};
      din_sy  <= {din_sy[0], DIN_I};
      bclk_d  <= bclk_sy[1];
    end
  end

  // ---------------- master bit clock ----------------
  // divider runs only as master; rate follows the interface rate
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      div_cnt <= '0;
      bclk_m  <= 1'b0;
    end else if (!(act_ctrl.enable && act_ctrl.master)) begin
      div_cnt <= '0;
      bclk_m  <= 1'b0;
    end else if (div_cnt == '0) begin
      div_cnt <= half_div(act_ctrl.rate_sel);
      bclk_m  <= ~bclk_m;
    end else begin
      div_cnt <= div_cnt - 1'b1;
    end
  end

  // edge events from own divider or from the synchronised pin
  always_comb begin
    if (act_ctrl.master) begin
      rise_ev = act_ctrl.enable && (div_cnt == '0) && !bclk_m;
      fall_ev = act_ctrl.enable && (div_cnt == '0) && bclk_m;
    end else begin
      rise_ev = act_ctrl.enable && bclk_sy[1] && !bclk_d;
      fall_ev = act_ctrl.enable && !bclk_sy[1] && bclk_d;
    end
  end

  // ---------------- frame geometry ----------------
  // slots per frame from interface rate and frame rate
  always_comb begin
    case (act_ctrl.fs_sel)
      FS_8K:   nslots = 5'(1 << act_ctrl.rate_sel);
      FS_16K:  nslots = 5'((1 << act_ctrl.rate_sel) >> 1);
      FS_4K:   nslots = 5'(2 << act_ctrl.rate_sel);
      default: nslots = 5'(1 << act_ctrl.rate_sel);
    endcase
    if (nslots == '0) begin
      nslots = 5'd1;
    end
    if (nslots > 5'(`PVP_MAX_SLOTS)) begin
      nslots = 5'(`PVP_MAX_SLOTS);
    end
    frame_last = 9'(nslots * `PVP_SLOT_BITS - 1);
  end

  // next bit index: slave resync wins over free running count
  assign next_bit_cnt = pend ? pend_val :
                        (bit_cnt >= frame_last) ? '0 : bit_cnt + 1'b1;

  // channel hits for the coming bit and the current bit
  genvar g;
  generate
    for (g = 0; g < `PVP_NUM_CH; g++) begin : g_hit
      assign hit_nx[g] = act_chan[g].en && (5'(act_chan[g].slot) < nslots) &&
                         (act_chan[g].slot == next_bit_cnt[7:4]);
      assign hit_cu[g] = act_chan[g].en && (5'(act_chan[g].slot) < nslots) &&
                         (act_chan[g].slot == bit_cnt[7:4]);
    end
  endgenerate

  // lowest channel wins if software maps two onto one slot
  always_comb begin
    ch_cu = '0;
    for (int i = `PVP_NUM_CH - 1; i >= 0; i--) begin
      if (hit_cu[i]) ch_cu = 2'(i);
    end
    own_nx = |hit_nx && !next_bit_cnt[8];
    own_cu = |hit_cu && !bit_cnt[8];
  end

  // ---------------- bit counter and sync ----------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bit_cnt  <= '0;
      pend     <= 1'b0;
      pend_val <= '0;
      prev_fs  <= 1'b0;
      sync_q   <= 1'b0;
    end else if (!act_ctrl.enable) begin
      bit_cnt  <= frame_last;  // first rise after enable opens bit zero, unless the enabling write also lengthens the frame
      pend     <= 1'b0;
      prev_fs  <= 1'b0;
      sync_q   <= 1'b0;
    end else begin
      if (fall_ev) begin
        prev_fs <= sync_sy[1];
        if (!act_ctrl.master && sync_sy[1] && !prev_fs) begin
          pend     <= 1'b1;
          pend_val <= act_ctrl.long_sync ? 9'd1 : 9'd0;
        end
      end
      if (rise_ev) begin
        bit_cnt <= next_bit_cnt;
        pend    <= 1'b0;
        if (act_ctrl.long_sync) begin
          sync_q <= (next_bit_cnt < 9'(`PVP_LONG_SYNC_BITS));
        end else begin
          sync_q <= (next_bit_cnt == frame_last);
        end
      end
    end
  end

  // ---------------- settings apply at frame edge ----------------
  // mid-frame changes would tear a slot, so the shadow waits
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      act_ctrl <= ctrl_s'(`PVP_CTRL_RST);
      act_fmt  <= fmt_s'(`PVP_FMT_RST);
      act_chan <= `PVP_SLOTS_RST;
    end else if (!act_ctrl.enable || (rise_ev && next_bit_cnt == '0)) begin
      act_ctrl <= shd_ctrl;
      act_fmt  <= shd_fmt;
      act_chan <= shd_chan;
    end
  end

  // ---------------- transmit word build ----------------
  always_comb begin
    logic [2:0] fill;
    fill = '0;
    case (act_fmt.fill_mode)
      FILL_ZERO: fill = '0;
      FILL_ONE:  fill = '1;
      FILL_SIGN: fill = {`PVP_FILL_BITS{tx_head[`PVP_SAMPLE_BITS-1]}};
      FILL_PROG: fill = act_fmt.fill_val;
      default:   fill = '0;
    endcase
    if (act_ctrl.raw16) begin
      tx_word = tx_head;
    end else if (act_fmt.right_just) begin
      tx_word = {fill, tx_head[`PVP_SAMPLE_BITS-1:0]};
    end else begin
      tx_word = {tx_head[`PVP_SAMPLE_BITS-1:0], fill};
    end
    if (!tx_out_val) begin
      tx_word = '0;
    end
    if (act_fmt.lsb_first) begin
      tx_word = rev16(tx_word);
    end
  end

  assign tx_pop = rise_ev && own_nx && (next_bit_cnt[3:0] == '0);

  // ---------------- serial output ----------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tx_sh <= '0;
      oe    <= 1'b0;
    end else if (!act_ctrl.enable) begin
      oe <= 1'b0;
    end else if (tx_pop) begin
      tx_sh <= tx_word;
      oe    <= 1'b1;
    end else if (rise_ev && oe) begin
      tx_sh <= {tx_sh[14:0], 1'b0};
    end else if (rel_q) begin
      oe <= 1'b0;
    end
  end

  // release one clock after the last fall, so a receiver sampling on
  // that very edge still sees the slot driven
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rel_q <= 1'b0;
    end else begin
      rel_q <= fall_ev && oe && (bit_cnt[3:0] == 4'hf);
    end
  end

  // ---------------- serial input ----------------
  assign rx_full = {rx_sh[14:0], din_sy[1]};

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rx_sh   <= '0;
      rx_push <= 1'b0;
      rx_data <= '0;
    end else begin
      rx_push <= 1'b0;
      if (fall_ev && own_cu) begin
        rx_sh <= rx_full;
        if (bit_cnt[3:0] == 4'hf) begin
          rx_push <= 1'b1;
          rx_data <= {ch_cu, rx_fmt(rx_full)};
        end
      end
    end
  end

  // received word back to a sign-extended sample; spare bits dropped, raw16 words returned whole
  function automatic logic [15:0] rx_fmt(input logic [15:0] v);
    logic [15:0] w;
    w = act_fmt.lsb_first ? rev16(v) : v;
    if (act_ctrl.raw16) begin
      return w;
    end else if (act_fmt.right_just) begin
      return {{`PVP_FILL_BITS{w[`PVP_SAMPLE_BITS-1]}}, w[`PVP_SAMPLE_BITS-1:0]};
    end
    return {{`PVP_FILL_BITS{w[`PVP_SLOT_BITS-1]}}, w[`PVP_SLOT_BITS-1:`PVP_FILL_BITS]};
  endfunction

  // staging fifos between bus and link; full tx stalls the bus
  pvp_fifo #(.W(`PVP_TX_W), .D(`PVP_FIFO_DEPTH)) u_tx_fifo (
    .clk_i       (CLK_I),
    .arst_n_i    (ARST_N_I),
    .in_valid_i  (wr_tx),
    .in_ready_o  (tx_in_rdy),
    .in_data_i   (PWDATA_I[15:0]),
    .out_valid_o (tx_out_val),
    .out_ready_i (tx_pop),
    .out_data_o  (tx_head)
  );

  pvp_fifo #(.W(`PVP_RX_W), .D(`PVP_FIFO_DEPTH)) u_rx_fifo (
    .clk_i       (CLK_I),
    .arst_n_i    (ARST_N_I),
    .in_valid_i  (rx_push),
    .in_ready_o  (rx_in_rdy),
    .in_data_i   (rx_data),
    .out_valid_o (rx_out_val),
    .out_ready_i (rx_pop),
    .out_data_o  (rx_head)
  );

  // ---------------- pins ----------------
  // bit clock and sync parked low unless master; the divider lags a mode change by a clock
  assign BCLK_O    = bclk_m && BCLK_OE_O;
  assign BCLK_OE_O = act_ctrl.enable && act_ctrl.master;
  assign SYNC_O    = sync_q && SYNC_OE_O;
  assign SYNC_OE_O = act_ctrl.enable && act_ctrl.master;
  assign DOUT_O    = tx_sh[15];
  assign DOUT_OE_O = oe;

  // ---------------- apb slave ----------------
  assign wr_hit    = (PADDR_I == `PVP_OFS_TXDATA);
  assign wr_tx     = PSEL_I && PENABLE_I && PWRITE_I && wr_hit;
  assign PREADY_O  = !(wr_tx && !tx_in_rdy);  // back-pressure on full tx
  assign acc       = PSEL_I && PENABLE_I && PREADY_O;
  assign rx_pop    = acc && !PWRITE_I && (PADDR_I == `PVP_OFS_RXDATA) && rx_out_val;
  assign PSLVERR_O = PSEL_I && PENABLE_I &&
                     !(PADDR_I inside {`PVP_OFS_CTRL, `PVP_OFS_FMT, `PVP_OFS_SLOTS,
                                       `PVP_OFS_STATUS, `PVP_OFS_TXDATA,
                                       `PVP_OFS_RXDATA});

  assign stat = '{active: act_ctrl.enable, overrun: overrun, underrun: underrun,
                  rx_full: !rx_in_rdy, rx_empty: !rx_out_val,
                  tx_full: !tx_in_rdy, tx_empty: !tx_out_val};

  // shadow settings written by software
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      shd_ctrl <= ctrl_s'(`PVP_CTRL_RST);
      shd_fmt  <= fmt_s'(`PVP_FMT_RST);
      shd_chan <= `PVP_SLOTS_RST;
    end else if (acc && PWRITE_I) begin
      case (PADDR_I)
        `PVP_OFS_CTRL:  shd_ctrl <= ctrl_s'(PWDATA_I[$bits(ctrl_s)-1:0]);
        `PVP_OFS_FMT:   shd_fmt  <= fmt_s'(PWDATA_I[$bits(fmt_s)-1:0]);
        `PVP_OFS_SLOTS: shd_chan <= PWDATA_I[$bits(chan_s)*`PVP_NUM_CH-1:0];
        default:        ;
      endcase
    end
  end

  // sticky errors; a new event wins over a same-cycle clear
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      underrun <= 1'b0;
      overrun  <= 1'b0;
    end else begin
      if (acc && PWRITE_I && PADDR_I == `PVP_OFS_STATUS) begin
        if (PWDATA_I[5]) underrun <= 1'b0;
        if (PWDATA_I[6]) overrun  <= 1'b0;
      end
      if (tx_pop && !tx_out_val) underrun <= 1'b1;
      if (rx_push && !rx_in_rdy) overrun  <= 1'b1;
    end
  end

  // read data latched in the setup cycle, stable through access
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PRDATA_O <= '0;
    end else if (PSEL_I && !PENABLE_I) begin
      case (PADDR_I)
        `PVP_OFS_CTRL:   PRDATA_O <= 32'(shd_ctrl);
        `PVP_OFS_FMT:    PRDATA_O <= 32'(shd_fmt);
        `PVP_OFS_SLOTS:  PRDATA_O <= 32'(shd_chan);
        `PVP_OFS_STATUS: PRDATA_O <= 32'(stat);
        `PVP_OFS_RXDATA: PRDATA_O <= rx_out_val ? 32'(rx_head) : '0;
        default:         PRDATA_O <= '0;
      endcase
    end
  end
endmodule // pcm_voice_port

// file: pcm_voice_port_defs.svh
// Purpose: named constants for the serial voice port
// Assumes: included by bare name from the package only
// Notes:   offsets are APB byte addresses, one aligned 32-bit word each
`ifndef PCM_VOICE_PORT_DEFS_SVH
`define PCM_VOICE_PORT_DEFS_SVH

// clocking and frame geometry
`define PVP_CLK_KHZ        100000
`define PVP_BASE_RATE_KHZ  128
`define PVP_SLOT_BITS      16
`define PVP_SAMPLE_BITS    13
`define PVP_FILL_BITS      3
`define PVP_LONG_SYNC_BITS 3
`define PVP_NUM_CH         3
`define PVP_MAX_SLOTS      16
`define PVP_XFER_BYTES     1040

// staging fifo
`define PVP_FIFO_DEPTH     16
`define PVP_TX_W           16
`define PVP_RX_W           18

// register offsets
`define PVP_OFS_CTRL       12'h000
`define PVP_OFS_FMT        12'h004
`define PVP_OFS_SLOTS      12'h008
`define PVP_OFS_STATUS     12'h00c
`define PVP_OFS_TXDATA     12'h010
`define PVP_OFS_RXDATA     12'h014

// reset values
`define PVP_CTRL_RST       9'h000
`define PVP_FMT_RST        7'h00
`define PVP_SLOTS_RST      15'h0000

`endif

// file: pcm_voice_port_pkg.sv
// Purpose: types shared by the serial voice port design
// Assumes: constants come from pcm_voice_port_defs.svh
// Notes:   packed structs fix the field layout of each register
package pcm_voice_port_pkg;
  `include "pcm_voice_port_defs.svh"

  // fill pattern for the three spare bits of a transmitted word
  typedef enum logic [1:0] {
    FILL_ZERO,
    FILL_ONE,
    FILL_SIGN,
    FILL_PROG
  } fill_e;

  // frame rate choice
  typedef enum logic [1:0] {
    FS_8K,
    FS_16K,
    FS_4K,
    FS_RSVD
  } fs_e;

  typedef struct packed {
    logic       raw16;      // 16-bit words passed untouched
    fs_e        fs_sel;     // frame rate
    logic [2:0] rate_sel;   // bit clock 128 kHz shifted left by this
    logic       long_sync;  // three-bit sync instead of one-bit
    logic       master;     // drive bit clock and sync
    logic       enable;     // port running
  } ctrl_s;

  typedef struct packed {
    logic [2:0] fill_val;   // programmed fill pattern
    fill_e      fill_mode;  // how spare bits are filled
    logic       lsb_first;  // shift order
    logic       right_just; // sample in low 13 bits
  } fmt_s;

  typedef struct packed {
    logic       en;         // channel in use
    logic [3:0] slot;       // slot index in the frame
  } chan_s;

  typedef struct packed {
    logic active;           // port running with current settings
    logic overrun;          // rx sample lost, sticky
    logic underrun;         // tx slot had no sample, sticky
    logic rx_full;
    logic rx_empty;
    logic tx_full;
    logic tx_empty;
  } status_s;
endpackage

// file: pcm_voice_port_chk.sv
// Purpose: port assertions for pcm_voice_port
// Assumes: master link timing; slave pins are async
// Notes:   bound to every instance of the port
`timescale 1ns/1ns
module pcm_voice_port_chk (
  input wire logic        CLK_I,     // clock
  input wire logic        ARST_N_I,  // reset
  input wire logic        PSEL_I,    // select
  input wire logic        PENABLE_I, // access
  input wire logic        PWRITE_I,  // write
  input wire logic [11:0] PADDR_I,   // address
  input wire logic        PREADY_O,  // ready
  input wire logic        PSLVERR_O, // error
  input wire logic        BCLK_O,    // bit clock
  input wire logic        BCLK_OE_O, // its enable
  input wire logic        SYNC_O,    // sync
  input wire logic        SYNC_OE_O, // its enable
  input wire logic        DOUT_O,    // data
  input wire logic        DOUT_OE_O  // its enable
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  logic [1:0] rises;
  // bit clock rises while sync is high, to tell short from long
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) rises <= 2'h0;
    else if (!SYNC_O) rises <= 2'h0;
    else if ($rose(BCLK_O)) rises <= rises + 2'h1;
  end
  sequence held8; DOUT_OE_O [*8]; endsequence
  AST_OE_PAIR: assert property (BCLK_OE_O == SYNC_OE_O)
    else $error("link enables differ");
  AST_SLAVE_LOW: assert property (!BCLK_OE_O |-> !BCLK_O && !SYNC_O)
    else $error("link outputs high in slave mode");
  AST_SYNC_EDGE: assert property ($rose(SYNC_O) |-> BCLK_O)
    else $error("sync not on bit clock rise");
  AST_SYNC_WIDTH: assert property ($fell(SYNC_O) |-> rises == 2'h1 || rises == 2'h3)
    else $error("sync width wrong");
  AST_OE_RELEASE: assert property ($fell(DOUT_OE_O) && BCLK_OE_O |-> !BCLK_O)
    else $error("data released before fall");
  AST_LAUNCH: assert property (DOUT_OE_O && $changed(DOUT_O) && BCLK_OE_O |-> BCLK_O)
    else $error("data changed while clock low");
  AST_SLOT_HOLD: assert property ($rose(DOUT_OE_O) |-> held8)
    else $error("slot drive too short");
  AST_READY: assert property (PSEL_I && PENABLE_I && !PWRITE_I |-> PREADY_O)
    else $error("read stalled");
  AST_UNMAPPED: assert property (PSEL_I && PENABLE_I && PADDR_I > 12'h014 |-> PSLVERR_O)
    else $error("unmapped access not refused");
endmodule // pcm_voice_port_chk
bind pcm_voice_port pcm_voice_port_chk u_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .BCLK_O(BCLK_O), .BCLK_OE_O(BCLK_OE_O),
  .SYNC_O(SYNC_O), .SYNC_OE_O(SYNC_OE_O), .DOUT_O(DOUT_O), .DOUT_OE_O(DOUT_OE_O));

// file: pvp_codec.sv
// Purpose: far-side codec model for the voice link
// Assumes: one channel in SLOT; FBITS per frame as master
// Notes:   data outside the slot toggles so stale bits never match
`timescale 1ns/1ns
module pvp_codec #(
  parameter int          SLOT  = 2,
  parameter int          FBITS = 128,
  parameter logic [15:0] WORD  = 16'h8005
) (
  input  wire logic   drive_i, // we are link master
  input  wire logic   long_i,  // three-bit sync
  input  wire logic   clr_i,   // forget captured word
  input  wire logic   bclk_i,  // wire bit clock
  input  wire logic   sync_i,  // wire sync
  input  wire logic   dout_i,  // device data
  input  wire logic   doe_i,   // device drives data
  output logic        bclk_o,  // our bit clock
  output logic        sync_o,  // our sync
  output logic        din_o,   // data to device
  output logic [15:0] cap_o,   // first word seen
  output logic [3:0]  cs_o,    // its slot
  output int          fr_o,    // syncs seen
  output int          flen_o   // bits in last frame
);
  logic [7:0]  bitn = 8'hff;
  logic        sf = 0, sr = 0;
  logic [15:0] sh = 0;
  initial {bclk_o, sync_o, din_o, cap_o, cs_o, fr_o, flen_o} = '0;
  // clock stands low unless we are master
  always #40 bclk_o = drive_i ? ~bclk_o : 1'b0;
  // launch on the rise; count restarts after a sync
  always @(posedge bclk_i) begin
    if (sr) flen_o <= bitn + 1;
    bitn = sr ? {7'h0, long_i} : bitn + 8'h1;
    if (drive_i) sync_o <= bitn == FBITS - 1;
    din_o <= bitn[7:4] == SLOT ? WORD[~bitn[3:0]] : ~din_o;
  end
  // capture at the fall, as a receiving side does
  always @(negedge bclk_i) begin
    sr <= sync_i && !sf;
    sf <= sync_i;
    if (sync_i && !sf) fr_o <= fr_o + 1;
    if (doe_i) sh = {sh[14:0], dout_i};
    if (clr_i) cap_o <= 16'h0;
    else if (doe_i && bitn[3:0] == 4'hf && sh != 0 && cap_o == 0) begin
      cap_o <= sh;
      cs_o <= bitn[7:4];
    end
  end
endmodule // pvp_codec

// file: test_pcm_voice_port.sv
// Purpose: bench for pcm_voice_port over apb and the link
// Assumes: codec model pvp_codec on the link
// Notes:   16 kHz frames at 2048 kHz keep runs short
`timescale 1ns/1ns
module test_pcm_voice_port;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, perr, pready, slv;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        bo, boe, so, soe, dout, doe, din, mb, ms, drive = 0, clr = 0, lng = 0;
  logic [15:0] cap;
  logic [3:0]  cs;
  int          fr, flen, k, failures = 0, tests_run = 0, cyc = 0;
  logic [11:0] ra[5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h040};
  logic [31:0] re[5] = '{32'h0, 32'h0, 32'h0, 32'h5, 32'h0};
  logic [2:0]  fill[4] = '{3'h0, 3'h7, 3'h7, 3'h5};
  wire         bclk = boe ? bo : mb;
  wire         sync = soe ? so : ms;
  always #5 clk = ~clk;
  pcm_voice_port DUT (.CLK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(slv), .BCLK_I(bclk), .BCLK_O(bo), .BCLK_OE_O(boe),
    .SYNC_I(sync), .SYNC_O(so), .SYNC_OE_O(soe), .DIN_I(din), .DOUT_O(dout),
    .DOUT_OE_O(doe));
  pvp_codec P (.drive_i(drive), .long_i(lng), .clr_i(clr), .bclk_i(bclk), .sync_i(sync),
    .dout_i(dout), .doe_i(doe), .bclk_o(mb), .sync_o(ms), .din_o(din), .cap_o(cap),
    .cs_o(cs), .fr_o(fr), .flen_o(flen));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard above the longest sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  // one apb transfer, held until ready
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    perr = slv;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  // new format lands at a frame start, then one word goes out
  task automatic run(string s, logic [31:0] f, logic [31:0] t, logic [15:0] e);
    int n;
    apb(1, 12'h004, f);
    clr <= 1;
    n = fr;
    wait (fr > n);
    @(posedge clk) clr <= 0;
    apb(1, 12'h010, t);
    n = fr;
    wait (cap !== 16'h0 || fr > n + 2);
    @(posedge clk);
    chk(s, {16'h0, e}, {16'h0, cap});
    chk("slot", 32'h2, {28'h0, cs});
    $display("test %s done", s);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    foreach (ra[i]) begin
      apb(0, ra[i], 0);
      chk("reset read", re[i], rd);
    end
    chk("unmapped", 32'h1, {31'h0, perr});
    apb(1, 12'h008, 32'h12);
    apb(1, 12'h000, 32'h63);
    for (int m = 0; m < 4; m++) begin
      run("fill", 32'h50 | m << 2, 32'h1abc, {13'h1abc, fill[m]});
    end
    apb(0, 12'h00c, 0);
    chk("underrun", 32'h1, {31'h0, rd[4]});
    chk("master", 32'h3, {30'h0, boe, soe});
    chk("frame bits", 32'd128, flen);
    run("lsb right", 32'h3, 32'h1abc, 16'h3d58);
    apb(1, 12'h000, 32'h163);
    run("raw16", 32'h0, 32'hbeef, 16'hbeef);
    apb(1, 12'h000, 32'h66);
    wait (!boe);
    @(posedge clk);
    apb(1, 12'h004, 32'h0);
    apb(1, 12'h000, 32'h67);
    lng <= 1;
    run("long sync", 32'h0, 32'h0abc, 16'h55e0);
    apb(1, 12'h000, 32'h61);
    lng <= 0;
    wait (!boe);
    @(posedge clk) drive <= 1;
    run("slave", 32'h0, 32'h0abc, 16'h55e0);
    chk("slave", 32'h0, {30'h0, boe, soe});
    repeat (16) apb(0, 12'h014, 0);
    k = fr;
    wait (fr > k + 1);
    @(posedge clk);
    apb(0, 12'h014, 0);
    chk("rx word", 32'hf000, rd);
    finish_test();
  end
endmodule // test_pcm_voice_port
